// ---- shared/rsc_pkg.sv ----
/*
 * rsc_pkg: register map, field positions, reset values, source
 * codes and the prescaler decode of the counter status/control
 * block. Assumes 32-bit AXI4-Lite data with 8-bit byte addresses.
 */
package rsc_pkg;

    // register byte addresses
    localparam logic [7:0] ADDR_SC        = 8'h00;
    localparam logic [7:0] ADDR_MOD       = 8'h04;
    localparam logic [7:0] ADDR_CNT       = 8'h08;
    localparam logic [7:0] ADDR_IRQ_STAT  = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_MASK  = 8'h10;

    // status/control field positions
    localparam int CLKS_LSB = 14;
    localparam int PS_LSB   = 8;
    localparam int FLAG_BIT = 7;
    localparam int IE_BIT   = 6;
    localparam int OE_BIT   = 4;

    // reset values
    localparam logic [1:0]  CLKS_RST   = 2'h0;
    localparam logic [2:0]  PS_RST     = 3'h0;
    localparam logic [15:0] MOD_RST    = 16'h0000;
    localparam logic [15:0] CNT_RST    = 16'h0000;
    localparam logic        TOGGLE_RST = 1'b1;

    // clock source codes and prescaler off code
    localparam logic [1:0] SRC_EXT = 2'h0;
    localparam logic [1:0] SRC_LPO = 2'h1;
    localparam logic [1:0] SRC_REF = 2'h2;
    localparam logic [1:0] SRC_BUS = 2'h3;
    localparam logic [2:0] PS_OFF  = 3'h0;

    // interrupt status bits
    localparam int IRQ_W      = 2;
    localparam int IRQ_MATCH  = 0;
    localparam int IRQ_TOGGLE = 1;

    // bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    localparam int TERM_W = 11;

    typedef struct packed {
        logic [1:0] clks;
        logic [2:0] ps;
        logic       ie;
        logic       oe;
    } rsc_ctrl_t;

    // divide ratio minus one for a source group and a select code
    function automatic logic [TERM_W-1:0] prescale_term(
        input logic       src_odd,
        input logic [2:0] ps
    );
        logic [TERM_W-1:0] t;
        t = 11'h000;
        case ({src_odd, ps})
            4'h1:    t = 11'h000;
            4'h2:    t = 11'h001;
            4'h3:    t = 11'h003;
            4'h4:    t = 11'h007;
            4'h5:    t = 11'h00F;
            4'h6:    t = 11'h01F;
            4'h7:    t = 11'h03F;
            4'h9:    t = 11'h07F;
            4'hA:    t = 11'h0FF;
            4'hB:    t = 11'h1FF;
            4'hC:    t = 11'h3FF;
            4'hD:    t = 11'h7FF;
            4'hE:    t = 11'h063;
            4'hF:    t = 11'h3E7;
            default: t = 11'h000;
        endcase
        return t;
    endfunction : prescale_term

endpackage : rsc_pkg

// ---- rtl/rsc_prescaler.sv ----
/*
 * rsc_prescaler: divides the selected source tick by term+1 and
 * gives one registered tick per period. Assumes src_tick is a
 * one-cycle strobe synchronous to aclk.
 */
`timescale 1ns/1ps
`default_nettype none

module rsc_prescaler (
    // clock and reset
    input  wire logic                      aclk,
    input  wire logic                      aresetn,
    // control
    input  wire logic                      clear,
    input  wire logic                      enable,
    input  wire logic [rsc_pkg::TERM_W-1:0] term,
    // ticks
    input  wire logic                      src_tick,
    output logic                           tick_out
);

    logic [rsc_pkg::TERM_W-1:0] div_count;

    // divider state, cleared on select change
    always_ff @(posedge aclk)
    begin
        if (!aresetn || clear)
        begin
            div_count <= '0;
            tick_out  <= 1'b0;
        end
        else
        begin
            tick_out <= 1'b0;
            if (enable && src_tick)
            begin
                if (div_count >= term)
                begin
                    div_count <= '0;
                    tick_out  <= 1'b1;
                end
                else
                begin
                    div_count <= div_count + 11'h001;
                end
            end
        end
    end

endmodule : rsc_prescaler

`default_nettype wire

// ---- rtl/rsc_top.sv ----
/*
 * rsc_top: status/control of a 16-bit real-time counter with
 * prescaler, match flag, interrupt and toggle pin, as an
 * AXI4-Lite slave. Assumes source ticks are one-cycle strobes
 * synchronous to aclk; the bus clock source ticks every cycle.
 */
// The register addresses and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

// How it works
// R1 - source 00 ext, 01 lpo, 10 ref, 11 bus
// R2 - prescaler select bits 10:8, 000 off
// R3 - new prescaler select clears divider and count
// R4 - even source: divide 1 to 64
// R5 - odd source: 128..2048, 100, 1000
// R6 - bit 7 match flag, set on match
// R7 - write one clears flag and request
// R8 - bit 6 enables the match interrupt
// R9 - bit 4 lets overflow toggle the pin
// R10 - reserved bits read zero, ignore writes
// R11 - source bits 15:14; change clears counters
// R12 - count equal modulo wraps to zero
// R13 - request is flag and enable, same cycle
module rsc_top (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi write address
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [7:0]  awaddr,
    // axi write data
    input  wire logic        wvalid,
    output logic             wready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    // axi write response
    output logic             bvalid,
    input  wire logic        bready,
    output logic [1:0]       bresp,
    // axi read address
    input  wire logic        arvalid,
    output logic             arready,
    input  wire logic [7:0]  araddr,
    // axi read data
    output logic             rvalid,
    input  wire logic        rready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    // clock source ticks
    input  wire logic        ext_osc_tick,
    input  wire logic        low_power_osc_clock,
    input  wire logic        internal_ref_clock,
    // device outputs
    output logic             irq,
    output logic             toggle_pin
);

    logic                      aw_held, w_held, next_aw_held, next_w_held;
    logic                      aw_take, w_take, ar_take, next_rvalid;
    logic [7:0]                aw_addr;
    logic [31:0]               w_data;
    logic [3:0]                w_strb;
    logic                      do_write, wr_known;
    logic                      sc_wr, mod_wr, stat_wr, mask_wr;
    rsc_pkg::rsc_ctrl_t        ctrl, next_ctrl;
    logic                      match_flag, next_match_flag, flag_clr;
    logic [15:0]               main_count, modulo, mod_live;
    logic [rsc_pkg::IRQ_W-1:0] irq_status, next_irq_status;
    logic [rsc_pkg::IRQ_W-1:0] irq_mask, next_irq_mask, irq_events;
    logic                      src_tick, pre_tick, pre_clear, ovf;
    logic [31:0]               rd_word;
    logic                      rd_known;

    // bus handshakes
    assign aw_take  = awvalid && awready;
    assign w_take   = wvalid && wready;
    assign ar_take  = arvalid && arready;
    assign do_write = aw_held && w_held && !bvalid;
    assign next_aw_held = aw_take || (aw_held && !do_write);
    assign next_w_held  = w_take || (w_held && !do_write);
    assign next_rvalid  = ar_take || (rvalid && !rready);

    // write address and data capture, either order
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            awready <= 1'b0;
            wready  <= 1'b0;
            aw_addr <= 8'h00;
            w_data  <= 32'h0000_0000;
            w_strb  <= 4'h0;
        end
        else
        begin
            aw_held <= next_aw_held;
            w_held  <= next_w_held;
            awready <= !next_aw_held;
            wready  <= !next_w_held;
            if (aw_take)
            begin
                aw_addr <= awaddr;
            end
            if (w_take)
            begin
                w_data <= wdata;
                w_strb <= wstrb;
            end
        end
    end

    // write decode
    assign sc_wr   = do_write && aw_addr == rsc_pkg::ADDR_SC;
    assign mod_wr  = do_write && aw_addr == rsc_pkg::ADDR_MOD;
    assign stat_wr = do_write && aw_addr == rsc_pkg::ADDR_IRQ_STAT;
    assign mask_wr = do_write && aw_addr == rsc_pkg::ADDR_IRQ_MASK;
    assign wr_known = sc_wr || mod_wr || stat_wr || mask_wr
                   || aw_addr == rsc_pkg::ADDR_CNT;

    // write response
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid <= 1'b0;
            bresp  <= rsc_pkg::RESP_OKAY;
        end
        else if (do_write)
        begin
            bvalid <= 1'b1;
            bresp  <= wr_known ? rsc_pkg::RESP_OKAY
                               : rsc_pkg::RESP_SLVERR;
        end
        else if (bready)
        begin
            bvalid <= 1'b0;
        end
    end

    // next control fields; only defined bits are taken
    always_comb
    begin
        next_ctrl = ctrl;
        if (sc_wr && w_strb[1])
        begin
            next_ctrl.clks = w_data[rsc_pkg::CLKS_LSB +: 2]; // [R11]
            next_ctrl.ps   = w_data[rsc_pkg::PS_LSB +: 3]; // [R2]
        end
        if (sc_wr && w_strb[0])
        begin
            next_ctrl.ie = w_data[rsc_pkg::IE_BIT]; // [R8]
            next_ctrl.oe = w_data[rsc_pkg::OE_BIT]; // [R9]
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl.clks <= rsc_pkg::CLKS_RST;
            ctrl.ps   <= rsc_pkg::PS_RST; // [R2]
            ctrl.ie   <= 1'b0;
            ctrl.oe   <= 1'b0;
        end
        else
        begin
            ctrl <= next_ctrl;
        end
    end

    // a changed source or select restarts divider and count
    assign pre_clear = sc_wr && (next_ctrl.clks != ctrl.clks
                              || next_ctrl.ps != ctrl.ps); // [R3] [R11]

    // source selection
    always_comb
    begin
        case (ctrl.clks) // [R1]
            rsc_pkg::SRC_EXT: src_tick = ext_osc_tick;
            rsc_pkg::SRC_LPO: src_tick = low_power_osc_clock;
            rsc_pkg::SRC_REF: src_tick = internal_ref_clock;
            rsc_pkg::SRC_BUS: src_tick = 1'b1;
            default:          src_tick = 1'b0;
        endcase
    end

    rsc_prescaler u_prescaler (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .clear    (pre_clear),
        .enable   (ctrl.ps != rsc_pkg::PS_OFF), // [R2]
        .term     (rsc_pkg::prescale_term(ctrl.clks[0],
                                          ctrl.ps)), // [R4] [R5]
        .src_tick (src_tick),
        .tick_out (pre_tick)
    );

    // overflow: count equal to the live modulo on a tick
    assign ovf = pre_tick && !pre_clear
              && main_count == mod_live; // [R12]

    // main count
    always_ff @(posedge aclk)
    begin
        if (!aresetn || pre_clear) // [R3]
        begin
            main_count <= rsc_pkg::CNT_RST;
        end
        else if (ovf)
        begin
            main_count <= rsc_pkg::CNT_RST; // [R12]
        end
        else if (pre_tick)
        begin
            main_count <= main_count + 16'h0001;
        end
    end

    // modulo, taken into use on overflow or while stopped
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            modulo   <= rsc_pkg::MOD_RST;
            mod_live <= rsc_pkg::MOD_RST;
        end
        else
        begin
            if (mod_wr && w_strb[0])
            begin
                modulo[7:0] <= w_data[7:0];
            end
            if (mod_wr && w_strb[1])
            begin
                modulo[15:8] <= w_data[15:8];
            end
            if (ovf || ctrl.ps == rsc_pkg::PS_OFF)
            begin
                mod_live <= modulo;
            end
        end
    end

    // match flag: set wins over a same-cycle clear
    assign flag_clr = sc_wr && w_strb[0]
                   && w_data[rsc_pkg::FLAG_BIT]; // [R7]
    assign next_match_flag = ovf || (match_flag && !flag_clr); // [R6]

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            match_flag <= 1'b0; // [R6]
        end
        else
        begin
            match_flag <= next_match_flag;
        end
    end

    // toggle pin
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            toggle_pin <= rsc_pkg::TOGGLE_RST;
        end
        else if (ovf && ctrl.oe)
        begin
            toggle_pin <= !toggle_pin; // [R9]
        end
    end

    // sticky event status and mask
    always_comb
    begin
        irq_events = '0;
        irq_events[rsc_pkg::IRQ_MATCH]  = ovf;
        irq_events[rsc_pkg::IRQ_TOGGLE] = ovf && ctrl.oe;
        next_irq_status = irq_status;
        if (stat_wr && w_strb[0])
        begin
            next_irq_status = irq_status & ~w_data[rsc_pkg::IRQ_W-1:0];
        end
        next_irq_status = next_irq_status | irq_events;
        next_irq_mask = irq_mask;
        if (mask_wr && w_strb[0])
        begin
            next_irq_mask = w_data[rsc_pkg::IRQ_W-1:0];
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            irq_status <= '0;
            irq_mask   <= '0;
        end
        else
        begin
            irq_status <= next_irq_status;
            irq_mask   <= next_irq_mask;
        end
    end

    // interrupt line follows the next state of its sources
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            irq <= 1'b0;
        end
        else
        begin
            irq <= (next_match_flag && next_ctrl.ie) // [R8] [R13] [R7]
                || |(next_irq_status & next_irq_mask);
        end
    end

    // read mux; unused bits stay zero
    always_comb
    begin
        rd_word  = 32'h0000_0000;
        rd_known = 1'b1;
        case (araddr)
            rsc_pkg::ADDR_SC:
            begin
                rd_word[rsc_pkg::CLKS_LSB +: 2] = ctrl.clks; // [R10]
                rd_word[rsc_pkg::PS_LSB +: 3]   = ctrl.ps;
                rd_word[rsc_pkg::FLAG_BIT]      = match_flag;
                rd_word[rsc_pkg::IE_BIT]        = ctrl.ie;
                rd_word[rsc_pkg::OE_BIT]        = ctrl.oe;
            end
            rsc_pkg::ADDR_MOD:      rd_word[15:0] = modulo;
            rsc_pkg::ADDR_CNT:      rd_word[15:0] = main_count;
            rsc_pkg::ADDR_IRQ_STAT: rd_word[rsc_pkg::IRQ_W-1:0] = irq_status;
            rsc_pkg::ADDR_IRQ_MASK: rd_word[rsc_pkg::IRQ_W-1:0] = irq_mask;
            default:                rd_known = 1'b0;
        endcase
    end

    // read channel
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= rsc_pkg::RESP_OKAY;
        end
        else
        begin
            arready <= !next_rvalid;
            rvalid  <= next_rvalid;
            if (ar_take)
            begin
                rdata <= rd_word;
                rresp <= rd_known ? rsc_pkg::RESP_OKAY
                                  : rsc_pkg::RESP_SLVERR;
            end
        end
    end

endmodule : rsc_top

`default_nettype wire

// ---- testbench/rsc_checker.sv ----
/*
 * rsc_checker: bus handshake, readback and output assertions.
 * Assumes it is bound to rsc_top and sees only its ports.
 */
`timescale 1ns/1ps
`default_nettype none

module rsc_checker (
    // clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // register bus
    input wire logic        awvalid,
    input wire logic        awready,
    input wire logic        wvalid,
    input wire logic        wready,
    input wire logic        bvalid,
    input wire logic        bready,
    input wire logic        arvalid,
    input wire logic        arready,
    input wire logic [7:0]  araddr,
    input wire logic        rvalid,
    input wire logic        rready,
    input wire logic [31:0] rdata,
    input wire logic [1:0]  rresp,
    // device outputs
    input wire logic        irq,
    input wire logic        toggle_pin
);
    logic [7:0] last_ar;

    // address of the read under way
    always_ff @(posedge aclk)
    begin
        if (arvalid && arready)
        begin
            last_ar <= araddr;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    reset_values_a: assert property (
        disable iff (1'b0) !aresetn |=> !irq && toggle_pin)
        else $error("irq or pin wrong after reset");
    write_answer_a: assert property (
        awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
        else $error("write response late");
    write_once_a: assert property (bvalid && bready |=> !bvalid)
        else $error("write response repeated");
    read_answer_a: assert property (arvalid && arready |=> rvalid)
        else $error("read data late");
    read_once_a: assert property (rvalid && rready |=> !rvalid)
        else $error("read data repeated");
    read_refused_a: assert property (rvalid |-> !arready)
        else $error("read address taken while data pending");
    sc_reserved_a: assert property (
        rvalid && last_ar == rsc_pkg::ADDR_SC |->
        (rdata & 32'hFFFF382F) == 32'h00000000)
        else $error("reserved control bits read nonzero");
    cnt_upper_a: assert property (
        rvalid && last_ar == rsc_pkg::ADDR_CNT |-> rdata[31:16] == 16'h0000)
        else $error("count upper half nonzero");
    unmapped_read_a: assert property (
        rvalid && last_ar == 8'h20 |->
        rresp == rsc_pkg::RESP_SLVERR && rdata == 32'h00000000)
        else $error("unmapped read not refused");
    irq_clear_a: assert property ($fell(irq) |-> $rose(bvalid))
        else $error("irq dropped without a write");
endmodule : rsc_checker

bind rsc_top rsc_checker i_rsc_checker (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .irq(irq), .toggle_pin(toggle_pin)
);

`default_nettype wire

// ---- testbench/testbench.sv ----
/*
 * testbench: self-checking bench for rsc_top over AXI4-Lite.
 * Assumes source ticks every 2 (ext), 3 (low power), 4 (ref) cycles.
 */
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic        aclk, aresetn, awvalid, awready, wvalid, wready;
    logic        bvalid, bready, arvalid, arready, rvalid, rready;
    logic        ext_osc_tick, low_power_osc_clock, internal_ref_clock;
    logic        irq, toggle_pin, pin_q;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, r;
    int          failures, check_count, tc, toggles, t0;

    rsc_top i_rsc_top (
        .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
        .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
        .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
        .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .rvalid(rvalid),
        .rready(rready), .rdata(rdata), .rresp(rresp),
        .ext_osc_tick(ext_osc_tick),
        .low_power_osc_clock(low_power_osc_clock),
        .internal_ref_clock(internal_ref_clock),
        .irq(irq), .toggle_pin(toggle_pin)
    );

    always #12.5 aclk = ~aclk;

    // source ticks and pin toggle counting
    always @(posedge aclk)
    begin
        tc <= (tc == 11) ? 0 : tc + 1;
        ext_osc_tick <= (tc % 2 == 0);
        low_power_osc_clock <= (tc % 3 == 0);
        internal_ref_clock <= (tc % 4 == 0);
        if (toggle_pin !== pin_q)
            toggles <= toggles + 1;
        pin_q <= toggle_pin;
    end

    task automatic stop_test();
        if (failures == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : stop_test

    task automatic check(input string name, input logic [31:0] seen, exp);
        check_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic hung(input int t);
        if (t >= 200)
        begin
            failures++;
            stop_test();
        end
    endtask : hung

    task automatic wr(input logic [7:0] a, input logic [31:0] v,
                      output logic [1:0] resp);
        int t;
        bit aw, w, b;
        aw = 0; w = 0; b = 0; t = 0;
        @(posedge aclk);
        awvalid <= 1; awaddr <= a; wvalid <= 1; wdata <= v;
        wstrb <= 4'hF; bready <= 1;
        while (!b && t < 200)
        begin
            @(posedge aclk);
            t++;
            if (aw && w && bvalid)
            begin
                b = 1; resp = bresp; bready <= 0;
            end
            if (!aw && awready)
            begin
                aw = 1; awvalid <= 0;
            end
            if (!w && wready)
            begin
                w = 1; wvalid <= 0;
            end
        end
        hung(t);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] v,
                      output logic [1:0] resp);
        int t;
        bit ar, got;
        ar = 0; got = 0; t = 0;
        @(posedge aclk);
        arvalid <= 1; araddr <= a; rready <= 1;
        while (!got && t < 200)
        begin
            @(posedge aclk);
            t++;
            if (ar && rvalid)
            begin
                got = 1; v = rdata; resp = rresp; rready <= 0;
            end
            if (!ar && arready)
            begin
                ar = 1; arvalid <= 0;
            end
        end
        hung(t);
    endtask : rd

    function automatic int div_of(input logic odd, input int p);
        if (!odd) return 1 << (p - 1);
        if (p == 6) return 100;
        if (p == 7) return 1000;
        return 128 << (p - 1);
    endfunction : div_of

    // eight prescaler periods, then the count must be about eight
    task automatic measure(input logic [1:0] src, input int p);
        int per, tol, got;
        per = div_of(src[0], p) * (src == 2'h3 ? 1 : (src == 2'h1 ? 3 : 2));
        tol = src[0] ? 1 : 2;
        wr(rsc_pkg::ADDR_SC, {16'h0000, src, 3'h0, p[2:0], 8'h00}, r);
        repeat (8 * per) @(posedge aclk);
        rd(rsc_pkg::ADDR_CNT, d, r);
        got = int'(d[15:0]);
        check("count_rate", {31'h0, got >= 8 - tol && got <= 8 + tol}, 1);
    endtask : measure

    task automatic reset_values();
        rd(rsc_pkg::ADDR_SC, d, r);
        check("sc_reset", d, 32'h00000000);
        check("pin_reset", {31'h0, toggle_pin}, 32'h00000001);
    endtask : reset_values

    task automatic prescale_table();
        wr(rsc_pkg::ADDR_MOD, 32'h0000FFFF, r);
        for (int s = 0; s < 2; s++)
            for (int p = 1; p < 8; p++)
                measure(s ? 2'h3 : 2'h0, p);
        measure(2'h1, 7);
    endtask : prescale_table

    task automatic flag_irq();
        wr(rsc_pkg::ADDR_SC, 32'h00008000, r);
        wr(rsc_pkg::ADDR_MOD, 32'h00000003, r);
        wr(rsc_pkg::ADDR_SC, 32'h00008100, r);
        repeat (40) @(posedge aclk);
        wr(rsc_pkg::ADDR_SC, 32'h00008000, r);
        rd(rsc_pkg::ADDR_SC, d, r);
        check("flag_set", d, 32'h00008080);
        check("irq_off", {31'h0, irq}, 32'h0);
        wr(rsc_pkg::ADDR_SC, 32'h00008040, r);
        check("irq_on", {31'h0, irq}, 32'h1);
        rd(rsc_pkg::ADDR_SC, d, r);
        check("flag_kept", d, 32'h000080C0);
        wr(rsc_pkg::ADDR_SC, 32'h000080C0, r);
        check("irq_cleared", {31'h0, irq}, 32'h0);
        rd(rsc_pkg::ADDR_SC, d, r);
        check("flag_cleared", d, 32'h00008040);
        rd(rsc_pkg::ADDR_IRQ_STAT, d, r);
        check("stat_match", d & 32'h1, 32'h1);
        wr(rsc_pkg::ADDR_IRQ_MASK, 32'h00000001, r);
        check("irq_masked_on", {31'h0, irq}, 32'h1);
        wr(rsc_pkg::ADDR_IRQ_STAT, 32'h00000001, r);
        check("irq_stat_clear", {31'h0, irq}, 32'h0);
        wr(rsc_pkg::ADDR_IRQ_MASK, 32'h00000000, r);
    endtask : flag_irq

    task automatic toggle_out();
        t0 = toggles;
        wr(rsc_pkg::ADDR_SC, 32'h00008110, r);
        repeat (160) @(posedge aclk);
        check("toggles_on", {31'h0, toggles - t0 >= 8 && toggles - t0 <= 11},
              32'h1);
        wr(rsc_pkg::ADDR_SC, 32'h00008100, r);
        @(posedge aclk);
        t0 = toggles;
        repeat (160) @(posedge aclk);
        check("toggles_off", toggles - t0, 32'h0);
        rd(rsc_pkg::ADDR_IRQ_STAT, d, r);
        check("stat_toggle", d & 32'h2, 32'h2);
    endtask : toggle_out

    task automatic odd_places();
        wr(8'h20, 32'hFFFFFFFF, r);
        check("unmapped_wr", r, rsc_pkg::RESP_SLVERR);
        rd(8'h20, d, r);
        check("unmapped_rd", r, rsc_pkg::RESP_SLVERR);
        wr(rsc_pkg::ADDR_CNT, 32'h00001234, r);
        check("cnt_write", r, rsc_pkg::RESP_OKAY);
        wr(rsc_pkg::ADDR_SC, 32'hFFFFFF7F, r);
        rd(rsc_pkg::ADDR_SC, d, r);
        check("sc_reserved", d & 32'hFFFFFF7F, 32'h0000C750);
    endtask : odd_places

    initial
    begin
        aclk = 0; aresetn = 0; awvalid = 0; wvalid = 0; bready = 0;
        arvalid = 0; rready = 0; awaddr = 8'h00; araddr = 8'h00;
        wdata = 32'h00000000; wstrb = 4'h0; tc = 0; toggles = 0;
        ext_osc_tick = 0; low_power_osc_clock = 0; internal_ref_clock = 0;
        pin_q = 1; failures = 0; check_count = 0;
        repeat (10) @(posedge aclk);
        aresetn <= 1;
        reset_values();
        prescale_table();
        flag_irq();
        toggle_out();
        odd_places();
        stop_test();
    end
endmodule : testbench

`default_nettype wire
